// ===== mps_monitor.sv
// checker: register shadow and pin routing assertions
module mps_monitor (
    input logic CORE_CLK,
    input logic RST,
    input logic [mps_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input logic S_AXI_AWVALID,
    input logic S_AXI_AWREADY,
    input logic [mps_pkg::DATA_W-1:0] S_AXI_WDATA,
    input logic [3:0] S_AXI_WSTRB,
    input logic S_AXI_WVALID,
    input logic S_AXI_WREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic S_AXI_BVALID,
    input logic [mps_pkg::CTRL_PINS-1:0] MEM_CTRL_OUT,
    input logic [mps_pkg::CTRL_PINS-1:0] GPIO_CTRL_OUT,
    input logic [mps_pkg::CTRL_PINS-1:0] GPIO_CTRL_OE,
    input logic [mps_pkg::CTRL_PINS-1:0] CTRL_PIN_OUT,
    input logic [mps_pkg::CTRL_PINS-1:0] CTRL_PIN_OE,
    input logic [mps_pkg::DATA_PINS-1:0] MEM_DATA_OUT,
    input logic MEM_DATA_OE,
    input logic [mps_pkg::DATA_PINS-1:0] GPIO_DATA_OUT,
    input logic [mps_pkg::DATA_PINS-1:0] GPIO_DATA_OE,
    input logic [mps_pkg::DATA_PINS-1:0] DATA_PIN_OUT,
    input logic [mps_pkg::DATA_PINS-1:0] DATA_PIN_OE
);
    logic [mps_pkg::ADDR_W-1:0] aw_a; // last taken write address
    logic [mps_pkg::DATA_W-1:0] w_d; // last taken write word
    logic [3:0] w_s; // its strobes
    logic [13:0] shadow; // expected register content
    logic ok_wr; // pending write should commit
    logic [mps_pkg::CTRL_PINS-1:0] sel; // expected routed control pins
    logic [mps_pkg::CTRL_PINS-1:0] exp_out; // expected control pin levels
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // capture of taken address and data
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_a <= '0;
            w_d <= '0;
            w_s <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) aw_a <= S_AXI_AWADDR;
            if (S_AXI_WVALID && S_AXI_WREADY) {w_s, w_d} <= {S_AXI_WSTRB, S_AXI_WDATA};
        end
    end
    assign ok_wr = (aw_a == mps_pkg::MEM_PIN_SELECT_ADDR) && (w_s == mps_pkg::FULL_WORD_STROBE);
    // shadow lags the design by one edge, so pin checks skip that edge
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) shadow <= '0;
        else if ($rose(S_AXI_BVALID) && ok_wr) shadow <= w_d[13:0];
    end
    assign sel = {{2{shadow[1:0] == 2'h3}}, {2{shadow[0]}}, shadow[2], shadow[3], shadow[4], shadow[5], shadow[6],
                  shadow[8], shadow[9], shadow[10], shadow[11], shadow[12], shadow[13]};
    assign exp_out = (sel & MEM_CTRL_OUT) | (~sel & GPIO_CTRL_OUT);
    chk_strobe_pin_route: assert property (!$rose(S_AXI_BVALID) |-> CTRL_PIN_OUT[1:0] == exp_out[1:0])
        else $error("strobe pins misrouted");
    chk_chip_select_route: assert property (!$rose(S_AXI_BVALID) |-> CTRL_PIN_OUT[5:2] == exp_out[5:2])
        else $error("chip select pins misrouted");
    chk_sdram_ctrl_route: assert property (!$rose(S_AXI_BVALID) |-> CTRL_PIN_OUT[10:6] == exp_out[10:6])
        else $error("sdram control pins misrouted");
    chk_data_mask_route: assert property (!$rose(S_AXI_BVALID) |-> CTRL_PIN_OUT[14:11] == exp_out[14:11])
        else $error("data mask pins misrouted");
    chk_ctrl_enable_sel: assert property (!$rose(S_AXI_BVALID) |-> CTRL_PIN_OE == (sel | GPIO_CTRL_OE))
        else $error("control pin enable wrong");
    chk_upper_data_out: assert property (!$rose(S_AXI_BVALID)
        |-> DATA_PIN_OUT == (shadow[7] ? MEM_DATA_OUT : GPIO_DATA_OUT))
        else $error("upper data pins misrouted");
    chk_upper_data_oe: assert property (!$rose(S_AXI_BVALID)
        |-> DATA_PIN_OE == (shadow[7] ? {16{MEM_DATA_OE}} : GPIO_DATA_OE))
        else $error("upper data enable wrong");
    chk_write_resp_code: assert property ($rose(S_AXI_BVALID)
        |-> S_AXI_BRESP == (ok_wr ? mps_pkg::RESP_OKAY : mps_pkg::RESP_SLVERR))
        else $error("write response code wrong");
    chk_release_quiet: assert property ($fell(RST) |-> !S_AXI_BVALID && !S_AXI_AWREADY)
        else $error("bus not idle after reset");
endmodule

// ===== mps_pin_if.sv
// interface: pin selection carried from the register file to the pin multiplexer
interface mps_pin_if;
    logic [mps_pkg::CTRL_PINS-1:0] ctrl_sel; // one per control pin, 1 routes the memory signal
    logic data_sel;                          // 1 routes the upper data half
    modport regs (output ctrl_sel, output data_sel);
    modport mux (input ctrl_sel, input data_sel);
endinterface

// ===== mps_pin_mux.sv
// module: per-pin choice between memory-interface signal and port bit
module mps_pin_mux (
    mps_pin_if.mux sel,
    input wire logic [mps_pkg::CTRL_PINS-1:0] mem_ctrl_out,
    input wire logic [mps_pkg::CTRL_PINS-1:0] gpio_ctrl_out,
    input wire logic [mps_pkg::CTRL_PINS-1:0] gpio_ctrl_oe,
    input wire logic [mps_pkg::DATA_PINS-1:0] mem_data_out,
    input wire logic mem_data_oe,
    input wire logic [mps_pkg::DATA_PINS-1:0] gpio_data_out,
    input wire logic [mps_pkg::DATA_PINS-1:0] gpio_data_oe,
    output logic [mps_pkg::CTRL_PINS-1:0] ctrl_pin_out,
    output logic [mps_pkg::CTRL_PINS-1:0] ctrl_pin_oe,
    output logic [mps_pkg::DATA_PINS-1:0] data_pin_out,
    output logic [mps_pkg::DATA_PINS-1:0] data_pin_oe
);
    // control pins: memory strobes are outputs only, so they always drive when chosen
    genvar i;
    generate
        for (i = 0; i < mps_pkg::CTRL_PINS; i++) begin : g_ctrl
            always_comb begin
                if (sel.ctrl_sel[i]) begin
                    ctrl_pin_out[i] = mem_ctrl_out[i]; // see R15
                    ctrl_pin_oe[i] = 1'b1;
                end else begin
                    ctrl_pin_out[i] = gpio_ctrl_out[i]; // see R15
                    ctrl_pin_oe[i] = gpio_ctrl_oe[i];
                end
            end
        end
    endgenerate

    // upper data half: direction follows the memory controller when routed
    always_comb begin
        if (sel.data_sel) begin
            data_pin_out = mem_data_out; // see R5
            data_pin_oe = {mps_pkg::DATA_PINS{mem_data_oe}};
        end else begin
            data_pin_out = gpio_data_out; // see R15
            data_pin_oe = gpio_data_oe;
        end
    end
endmodule

// ===== mps_pkg.sv
// package: register map, field layout and pin indices of the memory pin select block
package mps_pkg;
    // bus geometry
    localparam int ADDR_W = 12; // decoded byte address width
    localparam int DATA_W = 32; // bus data width
    localparam int CTRL_PINS = 15; // single-bit shared memory control pins
    localparam int DATA_PINS = 16; // upper data half pins
    // register byte addresses
    localparam logic [ADDR_W-1:0] MEM_PIN_SELECT_ADDR = 12'h000; // memory_pin_select
    localparam logic [ADDR_W-1:0] PIN_LEVEL_ADDR = 12'h020; // read-only pin level snapshot
    // memory_pin_select layout and reset
    localparam logic [DATA_W-1:0] MEM_PIN_SELECT_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] MEM_PIN_SELECT_MASK = 32'h00003FFF; // reserved 31:14 held at zero
    localparam int LANE3_STROBE_SEL_BIT = 13; // lane3_strobe_sel
    localparam int LANE2_STROBE_SEL_BIT = 12; // lane2_strobe_sel
    localparam int CHIP_SELECT6_SEL_BIT = 11; // chip_select6_sel
    localparam int CHIP_SELECT5_SEL_BIT = 10; // chip_select5_sel
    localparam int CHIP_SELECT4_SEL_BIT = 9; // chip_select4_sel
    localparam int CHIP_SELECT3_SEL_BIT = 8; // chip_select3_sel
    localparam int UPPER_DATA_HALF_ENABLE_BIT = 7; // upper_data_half_enable
    localparam int SDRAM_CLOCK_SEL_BIT = 6; // sdram_clock_sel
    localparam int SDRAM_CLOCK_EN_SEL_BIT = 5; // sdram_clock_en_sel
    localparam int SDRAM_CS1_SEL_BIT = 4; // sdram_cs1_sel
    localparam int SDRAM_CS0_SEL_BIT = 3; // sdram_cs0_sel
    localparam int SDRAM_WRITE_EN_SEL_BIT = 2; // sdram_write_en_sel
    localparam int DATA_MASK_GROUP_SEL_LSB = 0; // data_mask_group_sel, two bits
    // data_mask_group_sel encodings
    localparam logic [1:0] DQM_NONE = 2'h0; // all four pins are port bits (reset)
    localparam logic [1:0] DQM_LOW_PAIR = 2'h1; // masks 0 and 1 only
    localparam logic [1:0] DQM_NONE_ALT = 2'h2; // also all port bits
    localparam logic [1:0] DQM_ALL = 2'h3; // masks 0 to 3
    // index of each control pin in the CTRL vectors
    localparam int PIN_LANE3_STROBE = 0;
    localparam int PIN_LANE2_STROBE = 1;
    localparam int PIN_CHIP_SELECT6 = 2; // chip selects 6..3 at 2..5
    localparam int PIN_SDRAM_CLOCK = 6;
    localparam int PIN_SDRAM_CLOCK_EN = 7;
    localparam int PIN_SDRAM_CS1 = 8;
    localparam int PIN_SDRAM_CS0 = 9;
    localparam int PIN_SDRAM_WRITE_EN = 10;
    localparam int PIN_DATA_MASK0 = 11; // data masks 0..3 at 11..14
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] FULL_WORD_STROBE = 4'hF;
endpackage

// ===== mps_tail_none.sv
// file: intentionally holds no module; kept empty of logic

// ===== mps_top.sv
// module: memory pin select register behind an AXI4-Lite slave, driving the pin multiplexer
// What this block does
// R1 - bits 31 to 14 reserved, read zero
// R2 - bit 13 routes byte-lane strobe 3
// R3 - bit 12 routes byte-lane strobe 2
// R4 - bits 11..8 route static chip selects 6..3
// R5 - bit 7 routes upper data half
// R6 - bit 6 routes SDRAM clock
// R7 - bit 5 routes SDRAM clock enable
// R8 - bits 4,3 route SDRAM chip selects 1,0
// R9 - bit 2 routes SDRAM write enable
// R10 - mask field 11 routes all four masks
// R11 - 01 routes masks 0,1; others none
// R12 - mask field resets to 00
// R13 - whole register resets to zero
// R14 - software writes full 32-bit words only
// R15 - pin value and enable chosen combinationally
module mps_top (
    input wire logic CORE_CLK,
    input wire logic RST,
    // axi4-lite write address
    input wire logic [mps_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // axi4-lite write data
    input wire logic [mps_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read address
    input wire logic [mps_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // axi4-lite read data
    output logic [mps_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // memory controller side of the control pins
    input wire logic [mps_pkg::CTRL_PINS-1:0] MEM_CTRL_OUT,
    // port bit side of the control pins
    input wire logic [mps_pkg::CTRL_PINS-1:0] GPIO_CTRL_OUT,
    input wire logic [mps_pkg::CTRL_PINS-1:0] GPIO_CTRL_OE,
    output logic [mps_pkg::CTRL_PINS-1:0] GPIO_CTRL_IN,
    // upper data half, memory controller side
    input wire logic [mps_pkg::DATA_PINS-1:0] MEM_DATA_OUT,
    input wire logic MEM_DATA_OE,
    output logic [mps_pkg::DATA_PINS-1:0] MEM_DATA_IN,
    // upper data half, port bit side
    input wire logic [mps_pkg::DATA_PINS-1:0] GPIO_DATA_OUT,
    input wire logic [mps_pkg::DATA_PINS-1:0] GPIO_DATA_OE,
    output logic [mps_pkg::DATA_PINS-1:0] GPIO_DATA_IN,
    // package pins, split into in / out / enable
    input wire logic [mps_pkg::CTRL_PINS-1:0] CTRL_PIN_IN,
    output logic [mps_pkg::CTRL_PINS-1:0] CTRL_PIN_OUT,
    output logic [mps_pkg::CTRL_PINS-1:0] CTRL_PIN_OE,
    input wire logic [mps_pkg::DATA_PINS-1:0] DATA_PIN_IN,
    output logic [mps_pkg::DATA_PINS-1:0] DATA_PIN_OUT,
    output logic [mps_pkg::DATA_PINS-1:0] DATA_PIN_OE
);
    // the one writable software register
    logic [mps_pkg::DATA_W-1:0] memory_pin_select;
    // write channel bookkeeping
    logic aw_held; // an address is parked, waiting for its data
    logic w_held;  // data is parked, waiting for its address
    logic [mps_pkg::ADDR_W-1:0] aw_addr;
    logic [mps_pkg::DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    // read channel bookkeeping
    logic ar_take;
    logic next_rvalid;
    // pin synchronisers, first stage read only by the second
    logic [mps_pkg::CTRL_PINS-1:0] ctrl_meta;
    logic [mps_pkg::CTRL_PINS-1:0] ctrl_sync;
    logic [mps_pkg::DATA_PINS-1:0] data_meta;
    logic [mps_pkg::DATA_PINS-1:0] data_sync;
    // combinational pin choice from the mux
    logic [mps_pkg::CTRL_PINS-1:0] mux_ctrl_out;
    logic [mps_pkg::CTRL_PINS-1:0] mux_ctrl_oe;
    logic [mps_pkg::DATA_PINS-1:0] mux_data_out;
    logic [mps_pkg::DATA_PINS-1:0] mux_data_oe;

    mps_pin_if pin_sel ();

    // decode used by both the write and the read path
    function automatic logic is_select_reg(input logic [mps_pkg::ADDR_W-1:0] addr);
        is_select_reg = (addr == mps_pkg::MEM_PIN_SELECT_ADDR);
    endfunction

    function automatic logic is_level_reg(input logic [mps_pkg::ADDR_W-1:0] addr);
        is_level_reg = (addr == mps_pkg::PIN_LEVEL_ADDR);
    endfunction

    // handshakes of this cycle
    assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID & S_AXI_WREADY;
    assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    // commit one cycle after both halves are parked, and only with no response pending
    assign do_write = aw_held & w_held & ~S_AXI_BVALID;

    // next values of the write bookkeeping
    always_comb begin
        next_aw_held = (aw_held & ~do_write) | aw_take;
        next_w_held = (w_held & ~do_write) | w_take;
        next_bvalid = do_write | (S_AXI_BVALID & ~S_AXI_BREADY);
    end

    // parked flags
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
        end
    end

    // ready flags are registered; each channel reopens once its half is consumed and no write response is pending
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= ~next_aw_held & ~next_bvalid;
            S_AXI_WREADY <= ~next_w_held & ~next_bvalid;
        end
    end

    // capture address and data when each is taken, either order
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (aw_take) begin
                aw_addr <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
        end
    end

    // the register itself; reserved bits never store anything
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            memory_pin_select <= mps_pkg::MEM_PIN_SELECT_RESET; // see R13 see R12
        end else if (do_write && is_select_reg(aw_addr) && w_strb == mps_pkg::FULL_WORD_STROBE) begin
            // partial-word writes are dropped: lanes cannot be merged safely here
            memory_pin_select <= w_data & mps_pkg::MEM_PIN_SELECT_MASK; // see R1 see R14
        end
    end

    // write response; unmapped, read-only or partial writes answer slave error
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= mps_pkg::RESP_OKAY;
        end else begin
            S_AXI_BVALID <= next_bvalid;
            if (do_write) begin
                if (is_select_reg(aw_addr) && w_strb == mps_pkg::FULL_WORD_STROBE) begin
                    S_AXI_BRESP <= mps_pkg::RESP_OKAY;
                end else begin
                    S_AXI_BRESP <= mps_pkg::RESP_SLVERR; // see R14
                end
            end
        end
    end

    // read side: one read at a time, data one cycle after the address is taken
    always_comb begin
        next_rvalid = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);
    end

    // read address ready closes while a read answer is outstanding
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
        end else begin
            S_AXI_ARREADY <= ~next_rvalid;
        end
    end

    // read data and response, held until rready
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= mps_pkg::RESP_OKAY;
        end else begin
            S_AXI_RVALID <= next_rvalid;
            if (ar_take) begin
                if (is_select_reg(S_AXI_ARADDR)) begin
                    // mask again so reserved bits read zero whatever is stored
                    S_AXI_RDATA <= memory_pin_select & mps_pkg::MEM_PIN_SELECT_MASK; // see R1
                    S_AXI_RRESP <= mps_pkg::RESP_OKAY;
                end else if (is_level_reg(S_AXI_ARADDR)) begin
                    // live pin levels, useful to check a pin before handing it over
                    S_AXI_RDATA <= {data_sync, 1'b0, ctrl_sync};
                    S_AXI_RRESP <= mps_pkg::RESP_OKAY;
                end else begin
                    S_AXI_RDATA <= '0;
                    S_AXI_RRESP <= mps_pkg::RESP_SLVERR;
                end
            end
        end
    end

    // per-pin selection from the register fields
    always_comb begin
        pin_sel.ctrl_sel = '0;
        pin_sel.ctrl_sel[mps_pkg::PIN_LANE3_STROBE] =
            memory_pin_select[mps_pkg::LANE3_STROBE_SEL_BIT]; // see R2
        pin_sel.ctrl_sel[mps_pkg::PIN_LANE2_STROBE] =
            memory_pin_select[mps_pkg::LANE2_STROBE_SEL_BIT]; // see R3
        // chip selects 6..3 follow bits 11..8 in the same descending order
        for (int k = 0; k < 4; k++) begin
            pin_sel.ctrl_sel[mps_pkg::PIN_CHIP_SELECT6 + k] =
                memory_pin_select[mps_pkg::CHIP_SELECT6_SEL_BIT - k]; // see R4
        end
        pin_sel.ctrl_sel[mps_pkg::PIN_SDRAM_CLOCK] =
            memory_pin_select[mps_pkg::SDRAM_CLOCK_SEL_BIT]; // see R6
        pin_sel.ctrl_sel[mps_pkg::PIN_SDRAM_CLOCK_EN] =
            memory_pin_select[mps_pkg::SDRAM_CLOCK_EN_SEL_BIT]; // see R7
        pin_sel.ctrl_sel[mps_pkg::PIN_SDRAM_CS1] =
            memory_pin_select[mps_pkg::SDRAM_CS1_SEL_BIT]; // see R8
        pin_sel.ctrl_sel[mps_pkg::PIN_SDRAM_CS0] =
            memory_pin_select[mps_pkg::SDRAM_CS0_SEL_BIT]; // see R8
        pin_sel.ctrl_sel[mps_pkg::PIN_SDRAM_WRITE_EN] =
            memory_pin_select[mps_pkg::SDRAM_WRITE_EN_SEL_BIT]; // see R9
        // data mask group: both encodings 00 and 10 leave all four as port bits
        case (memory_pin_select[mps_pkg::DATA_MASK_GROUP_SEL_LSB +: 2])
            mps_pkg::DQM_ALL: begin
                pin_sel.ctrl_sel[mps_pkg::PIN_DATA_MASK0 +: 4] = 4'hF; // see R10
            end
            mps_pkg::DQM_LOW_PAIR: begin
                pin_sel.ctrl_sel[mps_pkg::PIN_DATA_MASK0 +: 4] = 4'h3; // see R11
            end
            mps_pkg::DQM_NONE_ALT: begin
                pin_sel.ctrl_sel[mps_pkg::PIN_DATA_MASK0 +: 4] = 4'h0; // see R11
            end
            default: begin
                pin_sel.ctrl_sel[mps_pkg::PIN_DATA_MASK0 +: 4] = 4'h0; // see R11
            end
        endcase
        pin_sel.data_sel = memory_pin_select[mps_pkg::UPPER_DATA_HALF_ENABLE_BIT]; // see R5
    end

    // the multiplexer itself
    mps_pin_mux u_mux (
        .sel(pin_sel.mux),
        .mem_ctrl_out(MEM_CTRL_OUT),
        .gpio_ctrl_out(GPIO_CTRL_OUT),
        .gpio_ctrl_oe(GPIO_CTRL_OE),
        .mem_data_out(MEM_DATA_OUT),
        .mem_data_oe(MEM_DATA_OE),
        .gpio_data_out(GPIO_DATA_OUT),
        .gpio_data_oe(GPIO_DATA_OE),
        .ctrl_pin_out(mux_ctrl_out),
        .ctrl_pin_oe(mux_ctrl_oe),
        .data_pin_out(mux_data_out),
        .data_pin_oe(mux_data_oe)
    );

    // pin drive stays combinational so the SDRAM clock and strobes keep their timing
    assign CTRL_PIN_OUT = mux_ctrl_out; // see R15
    assign CTRL_PIN_OE = mux_ctrl_oe;   // see R15
    assign DATA_PIN_OUT = mux_data_out; // see R15
    assign DATA_PIN_OE = mux_data_oe;   // see R15

    // two-stage synchronisers on everything read back from the pins
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ctrl_meta <= '0;
            ctrl_sync <= '0;
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            ctrl_meta <= CTRL_PIN_IN;
            ctrl_sync <= ctrl_meta;
            data_meta <= DATA_PIN_IN;
            data_sync <= data_meta;
        end
    end

    // pin levels handed to the users; the memory side sees zero while not routed
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            GPIO_CTRL_IN <= '0;
            GPIO_DATA_IN <= '0;
            MEM_DATA_IN <= '0;
        end else begin
            GPIO_CTRL_IN <= ctrl_sync;
            GPIO_DATA_IN <= data_sync;
            MEM_DATA_IN <= pin_sel.data_sel ? data_sync : '0; // see R5
        end
    end

    // protection bits carry nothing for this block
    logic unused_prot;
    assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT};
endmodule

// ===== mps_top_bench.sv
// testbench: register access, pin routing and refusals
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin fails++; $display("BAD %0t got %h want %h", $time, g, w); end end
module mps_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0; // core clock, 100 ns period
    logic rst = 1'h1; // held for 16 cycles
    logic [11:0] awaddr = '0, araddr = '0; // bus addresses
    logic [31:0] wdata = '0; // write word
    logic [3:0] wstrb = '0; // write strobes
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    // complementary patterns tell memory side from port side
    logic [14:0] m_ctrl = 15'h2AAA, g_out = 15'h5555, g_oe = '0, pin_in = '0;
    logic [15:0] m_data = 16'h3C3C, g_data = 16'hC3C3, g_doe = 16'h00FF, dpin_in = '0;
    logic m_oe = 1'h1; // memory data drive enable
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [14:0] c_out, c_oe, g_cin;
    logic [15:0] d_out, d_oe, m_din, g_din;
    int fails = 0, checks = 0;
    localparam logic [11:0] SEL = mps_pkg::MEM_PIN_SELECT_ADDR;
    localparam logic [3:0] ALL = mps_pkg::FULL_WORD_STROBE;
    localparam logic [1:0] OK = mps_pkg::RESP_OKAY, ERR = mps_pkg::RESP_SLVERR;
    mps_top dut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .MEM_CTRL_OUT(m_ctrl), .GPIO_CTRL_OUT(g_out), .GPIO_CTRL_OE(g_oe), .GPIO_CTRL_IN(g_cin),
        .MEM_DATA_OUT(m_data), .MEM_DATA_OE(m_oe), .MEM_DATA_IN(m_din), .GPIO_DATA_OUT(g_data),
        .GPIO_DATA_OE(g_doe), .GPIO_DATA_IN(g_din), .CTRL_PIN_IN(pin_in), .CTRL_PIN_OUT(c_out),
        .CTRL_PIN_OE(c_oe), .DATA_PIN_IN(dpin_in), .DATA_PIN_OUT(d_out), .DATA_PIN_OE(d_oe));
    // free-running clock
    initial begin
        forever #50 clk = ~clk;
    end
    // verdict and end of run
    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one write; each channel dropped once taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                `CHK(bresp, r)
                break;
            end
        end
        bready <= 1'h0;
        if (n >= 50) begin
            fails++;
            conclude();
        end
    endtask
    // one read; data and code taken at the edge that sees rvalid
    task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                `CHK(rdata, d)
                `CHK(rresp, r)
                break;
            end
        end
        rready <= 1'h0;
        if (n >= 50) begin
            fails++;
            conclude();
        end
    endtask
    // pins settle combinationally, looked at 10 ns after the clock edge
    task automatic check_ctrl(input logic [14:0] route);
        #10;
        `CHK(c_oe, route | g_oe)
        `CHK(c_out, (route & m_ctrl) | (~route & g_out))
    endtask
    task automatic check_data(input logic on);
        #10;
        `CHK(d_out, on ? m_data : g_data)
        `CHK(d_oe, on ? {16{m_oe}} : g_doe)
    endtask
    // reset state: register zero, all pins on the port side
    task automatic t_reset;
        axi_read(SEL, 32'h0, OK);
        g_oe <= 15'h1234;
        check_ctrl(15'h0000);
        check_data(1'h0);
        g_oe <= '0;
    endtask
    // each single control-pin select bit (13..8, 6..2) routes exactly its own pin
    task automatic t_single_bits;
        for (int k = 0; k < 11; k++) begin
            axi_write(SEL, 32'h1 << (k < 6 ? 13 - k : 12 - k), ALL, OK);
            check_ctrl(15'h0001 << k);
        end
    endtask
    // all four data mask encodings
    task automatic t_masks;
        for (int c = 0; c < 4; c++) begin
            axi_write(SEL, c, ALL, OK);
            check_ctrl(c == 3 ? 15'h7800 : (c == 1 ? 15'h1800 : 15'h0000));
        end
    endtask
    // all ones: reserved bits drop, everything routed, input levels cross
    task automatic t_all_ones;
        axi_write(SEL, 32'hFFFFFFFF, ALL, OK);
        axi_read(SEL, 32'h3FFF, OK);
        pin_in <= 15'h1357;
        dpin_in <= 16'hBEEF;
        check_ctrl(15'h7FFF);
        check_data(1'h1);
        repeat (4) @(posedge clk);
        #10;
        `CHK(g_cin, 15'h1357)
        `CHK(m_din, 16'hBEEF)
        `CHK(g_din, 16'hBEEF)
        axi_read(12'h020, 32'hBEEF1357, OK);
    endtask
    // partial, unmapped and read-only writes refused without effect
    task automatic t_refused;
        axi_write(SEL, 32'h0, 4'h3, ERR);
        axi_read(SEL, 32'h3FFF, OK);
        axi_write(SEL, 32'h0, ALL, OK);
        axi_write(12'h040, 32'h80, ALL, ERR);
        axi_write(12'h020, 32'h80, ALL, ERR);
        axi_read(12'h040, 32'h0, ERR);
        check_data(1'h0);
        repeat (4) @(posedge clk);
        #10;
        `CHK(m_din, 16'h0000)
    endtask
    // reset in mid-run returns the register to zero
    task automatic t_mid_reset;
        axi_write(SEL, 32'h2080, ALL, OK);
        check_ctrl(15'h0001);
        check_data(1'h1);
        @(posedge clk);
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        axi_read(SEL, 32'h0, OK);
        check_ctrl(15'h0000);
        check_data(1'h0);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_reset();
        t_single_bits();
        t_masks();
        t_all_ones();
        t_refused();
        t_mid_reset();
        conclude();
    end
endmodule
bind mps_top mps_monitor u_mon (.CORE_CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .MEM_CTRL_OUT, .GPIO_CTRL_OUT,
    .GPIO_CTRL_OE, .CTRL_PIN_OUT, .CTRL_PIN_OE, .MEM_DATA_OUT, .MEM_DATA_OE, .GPIO_DATA_OUT, .GPIO_DATA_OE,
    .DATA_PIN_OUT, .DATA_PIN_OE);
